//--- design/rcl_pkg.sv
package rcl_pkg;

  // Number of analog peripherals that can raise reference requests
  localparam int unsigned RCL_NUM_REQ = 4;

  // Register offsets on the plain register port
  localparam logic [3:0] RCL_OFS_CTRL = 4'h0;
  localparam logic [3:0] RCL_OFS_LEGACY = 4'h1;
  localparam logic [3:0] RCL_OFS_STATUS = 4'h2;

  // Control register field positions
  localparam int unsigned RCL_CTRL_FORCE_ON_BIT = 0;
  localparam int unsigned RCL_CTRL_OUT_EN_BIT = 1;
  localparam int unsigned RCL_CTRL_TC_DIS_BIT = 2;
  localparam int unsigned RCL_CTRL_VSEL_LSB = 4;
  localparam int unsigned RCL_CTRL_MASTER_BIT = 7;

  // Legacy converter field positions
  localparam int unsigned RCL_LEG_ON_BIT = 0;
  localparam int unsigned RCL_LEG_HIGH_BIT = 1;
  localparam int unsigned RCL_LEG_TC_OFF_BIT = 2;
  localparam int unsigned RCL_LEG_OUT_BIT = 3;
  localparam int unsigned RCL_LEG_SPEED_BIT = 4;
  localparam int unsigned RCL_LEG_BURST_BIT = 5;

  // Status register field positions
  localparam int unsigned RCL_STS_GEN_EN_BIT = 0;
  localparam int unsigned RCL_STS_SAMPLED_BIT = 1;
  localparam int unsigned RCL_STS_MASTER_BIT = 2;

  // Reset values: master select set by default
  localparam logic [7:0] RCL_CTRL_RESET = 8'h80;
  localparam logic [7:0] RCL_LEGACY_RESET = 8'h00;

  // Device variants
  localparam logic [1:0] RCL_VAR_TWELVE = 2'h0;
  localparam logic [1:0] RCL_VAR_TEN = 2'h1;
  localparam logic [1:0] RCL_VAR_SIGMA = 2'h2;

  // Variable level encodings
  typedef enum logic [1:0] {
    RCL_LVL_1V5 = 2'h0,
    RCL_LVL_2V0 = 2'h1,
    RCL_LVL_2V5 = 2'h2
  } rcl_level_t;

  // Low-power oscillator duty: on for one of this many cycles
  localparam logic [3:0] RCL_DUTY_PERIOD = 4'h8;

  // Per-module request bundle
  typedef struct packed {
    logic [RCL_NUM_REQ-1:0] gen;
    logic [RCL_NUM_REQ-1:0] bg;
    logic [RCL_NUM_REQ-1:0] sampled;
  } rcl_req_t;

  // Analog control bundle
  typedef struct packed {
    logic gen_en;
    logic bandgap_en;
    logic bandgap_clk_en;
    logic sampled;
    rcl_level_t level;
    logic ext_buf_en;
    logic bg_line_en;
    logic temp_en;
    logic afe_bias_en;
    logic burst_en;
    logic speed;
  } rcl_analog_t;

endpackage

//--- design/rcl_bg_sampler.sv
`timescale 1ns/1ps
// Reduced duty-cycle clock gate for the bandgap, paced by the oscillator tick
module rcl_bg_sampler
  import rcl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic osc_tick_i,
  input wire logic sampled_i,
  input wire logic enable_i,
  output logic bg_clk_en_o
);

  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic gate_r;
  logic gate_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Next state: static mode keeps the gate solid on
  always_comb
  begin
    cnt_nxt = cnt_r;
    gate_nxt = 1'b0;
    if (!enable_i)
    begin
      cnt_nxt = 4'h0;
    end
    else if (!sampled_i)
    begin
      cnt_nxt = 4'h0;
      gate_nxt = 1'b1;
    end
    else if (osc_tick_i)
    begin
      gate_nxt = (cnt_r == 4'h0);
      cnt_nxt = (cnt_r == RCL_DUTY_PERIOD - 4'h1) ? 4'h0 : cnt_r + 4'h1;
    end
    else
    begin
      gate_nxt = gate_r;
    end
  end

  // Registers
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt_r <= 4'h0;
      gate_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      gate_r <= gate_nxt;
    end
  end

  assign bg_clk_en_o = gate_r;

endmodule

//--- design/rcl_top.sv
`timescale 1ns/1ps
// Operation
// - Sampled mode clocks bandgap from oscillator at reduced duty; else static.
// - Any active static request forces static mode for all.
// - Master select 1 (reset default) takes control from central register.
// - Master set on twelve-bit: legacy on/level/temp/out ignored; speed, burst still act.
// - Master clear: central settings ignored, legacy bits govern reference.
// - Force-on keeps generator and bandgap enabled; level buffer also needs output enable.
// - Force-on clear disables generator only with no generator request pending.
// - Level select picks 1.5/2.0/2.5 V when generator is on.
// - Non-sigma-delta: output enable routes level line off-chip via buffer.
// - Temperature sensor disable bit switches sensor off.
// - Sigma-delta: force-on also enables analog front-end biases.
// - Sigma-delta: output enable drives buffered bandgap line when on or requested.
// - Generator request is OR of all module generator requests.
// - Mode request is AND of module sampled requests; 1 means sampled.
// - A module's mode request counts only while it requests generator or bandgap.
// - Readable indicator shows static or sampled bandgap operation.
module rcl_top
  import rcl_pkg::*;
#(
  parameter logic [1:0] VARIANT = 2'h0,
  parameter logic HAS_TEMP_SENSOR = 1'b1
)
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire rcl_pkg::rcl_req_t req_i,
  input wire logic osc_tick_i,
  output rcl_pkg::rcl_analog_t analog_o
);

  logic rst_meta_r;
  logic rst_sync_r;
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] legacy_r;
  logic [7:0] legacy_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  rcl_analog_t ana_r;
  rcl_analog_t ana_nxt;
  logic master;
  logic force_on;
  logic out_en;
  logic tc_dis;
  rcl_level_t level;
  logic gen_req;
  logic bg_req;
  logic mode_req;
  logic sampled;
  logic gen_en;
  logic bg_clk_en;

  // Convert a raw two-bit level field, holding the reserved code at 1.5 V
  function automatic rcl_level_t rcl_decode_level(input logic [1:0] raw);
    rcl_level_t lv;
    case (raw)
      2'h1: lv = RCL_LVL_2V0;
      2'h2: lv = RCL_LVL_2V5;
      default: lv = RCL_LVL_1V5;
    endcase
    return lv;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and read data
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    legacy_nxt = legacy_r;
    rdata_nxt = 8'h00;
    if (wr_i)
    begin
      case (addr_i)
        RCL_OFS_CTRL: ctrl_nxt = wdata_i & 8'hb7;
        RCL_OFS_LEGACY: legacy_nxt = wdata_i & 8'h3f;
        default: ctrl_nxt = ctrl_r;
      endcase
    end
    if (rd_i)
    begin
      case (addr_i)
        RCL_OFS_CTRL: rdata_nxt = ctrl_r;
        RCL_OFS_LEGACY: rdata_nxt = legacy_r;
        RCL_OFS_STATUS:
        begin
          rdata_nxt[RCL_STS_GEN_EN_BIT] = ana_r.gen_en;
          rdata_nxt[RCL_STS_SAMPLED_BIT] = ana_r.sampled;
          rdata_nxt[RCL_STS_MASTER_BIT] = master;
        end
        default: rdata_nxt = 8'h00; // Unmapped reads as zero
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      ctrl_r <= RCL_CTRL_RESET;
      legacy_r <= RCL_LEGACY_RESET;
      rdata_r <= 8'h00;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      legacy_r <= legacy_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_o = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Source selection. Legacy mode only exists on the twelve-bit converter;
  // other variants pin master high in case software misbehaves.
  // legacy unsupported elsewhere
  assign master = ctrl_r[RCL_CTRL_MASTER_BIT] | (VARIANT != RCL_VAR_TWELVE);

  always_comb
  begin
    force_on = ctrl_r[RCL_CTRL_FORCE_ON_BIT];
    out_en = ctrl_r[RCL_CTRL_OUT_EN_BIT];
    tc_dis = ctrl_r[RCL_CTRL_TC_DIS_BIT];
    level = rcl_decode_level(ctrl_r[RCL_CTRL_VSEL_LSB +: 2]);
    if (!master)
    begin
      force_on = legacy_r[RCL_LEG_ON_BIT];
      out_en = legacy_r[RCL_LEG_OUT_BIT];
      tc_dis = legacy_r[RCL_LEG_TC_OFF_BIT];
      level = legacy_r[RCL_LEG_HIGH_BIT] ? RCL_LVL_2V5 : RCL_LVL_1V5;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request combination
  always_comb
  begin
    gen_req = |req_i.gen;
    bg_req = |req_i.bg;
    mode_req = 1'b1;
    for (int i = 0; i < RCL_NUM_REQ; i++)
    begin
      if (req_i.gen[i] || req_i.bg[i])
      begin
        mode_req = mode_req & req_i.sampled[i];
      end
    end
  end

  assign gen_en = force_on | gen_req;

  // static overrides sampled; force-on with no voter stays static
  assign sampled = mode_req & (gen_req | bg_req) & ~force_on;

  ////////////////////////////////////////////////////////////////////////////
  // Duty-cycle gate for sampled operation
  // oscillator-paced sampling
  rcl_bg_sampler u_sampler (
    .clk_i(clk_i),
    .rst_b_i(rst_sync_r),
    .osc_tick_i(osc_tick_i),
    .sampled_i(sampled),
    .enable_i(gen_en | bg_req),
    .bg_clk_en_o(bg_clk_en)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Analog control outputs, registered so the analog side sees clean levels
  always_comb
  begin
    ana_nxt = '0;
    ana_nxt.gen_en = gen_en;
    ana_nxt.bandgap_en = gen_en | bg_req;
    ana_nxt.bandgap_clk_en = bg_clk_en;
    ana_nxt.sampled = sampled;
    ana_nxt.level = gen_en ? level : RCL_LVL_1V5;
    if (VARIANT == RCL_VAR_SIGMA)
    begin
      ana_nxt.afe_bias_en = force_on;
      ana_nxt.bg_line_en = out_en & (force_on | bg_req);
    end
    else
    begin
      ana_nxt.ext_buf_en = out_en & gen_en;
    end
    ana_nxt.temp_en = HAS_TEMP_SENSOR & force_on & ~tc_dis;
    // Speed and burst always come from the converter
    ana_nxt.burst_en = legacy_r[RCL_LEG_BURST_BIT] & force_on;
    ana_nxt.speed = legacy_r[RCL_LEG_SPEED_BIT];
  end

  always_ff @(posedge clk_i or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      ana_r <= '0;
    end
    else
    begin
      ana_r <= ana_nxt;
    end
  end

  assign analog_o = ana_r;

endmodule

//--- tb/rcl_monitor.sv
`timescale 1ns/1ps
// Port checks of the reference control block
module rcl_monitor
  import rcl_pkg::*;
#(
  parameter logic [1:0] VARIANT = 2'h0
)
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire rcl_pkg::rcl_req_t req_i,
  input wire rcl_pkg::rcl_analog_t analog_o
);
  logic [RCL_NUM_REQ-1:0] act;
  logic stat_vote;
  logic [3:0] run_r;
  logic [3:0] run_nxt;
  // A vote counts only from a module that requests something
  assign act = req_i.gen | req_i.bg;
  assign stat_vote = |(act & ~req_i.sampled);
  // Length of an unbroken gate-high run in sampled mode
  always_comb run_nxt = (analog_o.sampled && analog_o.bandgap_clk_en) ? run_r + 4'h1 : 4'h0;
  always_ff @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i)
      run_r <= 4'h0;
    else
      run_r <= run_nxt;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  a_gen_on_req:
  assert property (|req_i.gen |=> analog_o.gen_en) else $error("gen_en missing");
  a_bg_on_req:
  assert property (|act |=> analog_o.bandgap_en) else $error("bandgap_en missing");
  a_static_wins:
  assert property (stat_vote |=> !analog_o.sampled) else $error("sampled despite static vote");
  a_mode_needs_req:
  assert property (act == '0 |=> !analog_o.sampled) else $error("sampled with no voter");
  a_static_clk_on:
  assert property ((analog_o.bandgap_en && !analog_o.sampled) [*3] |-> analog_o.bandgap_clk_en) else $error("gate off");
  a_clk_off_idle:
  assert property (!analog_o.bandgap_en [*3] |-> !analog_o.bandgap_clk_en) else $error("gate on while off");
  a_duty_reduced:
  assert property (run_r < 4'hc) else $error("gate solid in sampled mode");
  a_level_off:
  assert property (!analog_o.gen_en |-> analog_o.level == RCL_LVL_1V5) else $error("level while off");
  a_ext_needs_gen:
  assert property (VARIANT != RCL_VAR_SIGMA && analog_o.ext_buf_en |-> analog_o.gen_en) else $error("buffer alone");
endmodule
bind rcl_top rcl_monitor #(.VARIANT(VARIANT)) rcl_monitor_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req_i),
  .analog_o(analog_o));

//--- tb/rcl_req_model.sv
`timescale 1ns/1ps
// Peripherals raising request levels; slow mode takes a change every other cycle
module rcl_req_model
  import rcl_pkg::*;
(
  input wire logic clk_i,
  input wire logic slow_i,
  input wire rcl_pkg::rcl_req_t want_i,
  output rcl_pkg::rcl_req_t req_o
);
  logic skip_r = 1'b0;
  initial req_o = '0;
  // Requests stay up until withdrawn
  always @(posedge clk_i)
  begin
    skip_r <= slow_i & ~skip_r;
    if (!skip_r)
      req_o <= want_i;
  end
endmodule

//--- tb/rcl_top_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; $display("[ERR] %0t %h %h", $time, a, b); end end
module rcl_top_tb_top
  import rcl_pkg::*;
;
  logic clk_i = 1'b0, rst_b_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, osc_tick_i = 1'b0, slow = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] rdata_o, d;
  logic [31:0] seed = 32'ha9ec0ae9;
  rcl_req_t want = '0;
  rcl_req_t w, req_i;
  rcl_analog_t analog_o;
  rcl_analog_t analog_s;
  logic wr_sd;
  int miscompares = 0, compares = 0, cyc = 0;
  always #20 clk_i = ~clk_i;
  // Oscillator tick every fifth cycle; the cycle ceiling cuts a hang
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    osc_tick_i <= (cyc % 5 == 0);
    if (cyc == 5000)
    begin
      miscompares++;
      finish_test();
    end
  end
  rcl_top rcl_top_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .req_i(req_i), .osc_tick_i(osc_tick_i), .analog_o(analog_o));
  rcl_req_model rcl_req_model_inst (.clk_i(clk_i), .slow_i(slow), .want_i(want), .req_o(req_i));
  // sigma-delta copy never sees master cleared
  assign wr_sd = wr_i & ~(addr_i == RCL_OFS_CTRL && !wdata_i[RCL_CTRL_MASTER_BIT]);
  // Sigma-delta copy on the same bus and requests, for the variant-only outputs
  rcl_top #(.VARIANT(RCL_VAR_SIGMA), .HAS_TEMP_SENSOR(1'b1)) rcl_top_sd_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_sd), .rd_i(rd_i), .rdata_o(), .req_i(req_i),
    .osc_tick_i(osc_tick_i), .analog_o(analog_s));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Sampled only if some module votes and none votes static
  function automatic logic exp_smp(input rcl_req_t r);
    logic [RCL_NUM_REQ-1:0] a;
    a = r.gen | r.bg;
    return (a != '0) && ((a & ~r.sampled) == '0);
  endfunction
  // One register cycle; read data land one cycle after the strobe
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= wr;
    rd_i <= ~wr;
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic settle;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task automatic finish_test;
    if (miscompares == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    bus(1'b0, RCL_OFS_CTRL, 8'h00);
    `CHK(d, RCL_CTRL_RESET)
    bus(1'b0, 4'hf, 8'h00);
    `CHK(d, 8'h00)
    // Every legacy bit set while the central register is in charge
    bus(1'b1, RCL_OFS_LEGACY, 8'h3f);
    settle();
    `CHK(analog_o.gen_en, 1'b0)
    `CHK(analog_o.speed, 1'b1)
    `CHK(analog_o.burst_en, 1'b0)
    bus(1'b1, RCL_OFS_CTRL, 8'h81);
    settle();
    `CHK(analog_o.burst_en, 1'b1)
    `CHK(analog_o.ext_buf_en, 1'b0)
    `CHK(analog_o.level, RCL_LVL_1V5)
    `CHK(analog_o.temp_en, 1'b1)
    `CHK(analog_s.afe_bias_en, 1'b1)
    `CHK(analog_s.bg_line_en, 1'b0)
    bus(1'b1, RCL_OFS_LEGACY, 8'h00);
    for (int v = 0; v < 3; v++)
    begin
      bus(1'b1, RCL_OFS_CTRL, 8'h81 | 8'(v << 4));
      settle();
      `CHK(analog_o.gen_en, 1'b1)
      `CHK(analog_o.level, rcl_level_t'(v))
    end
    bus(1'b1, RCL_OFS_CTRL, 8'h83);
    settle();
    `CHK(analog_o.ext_buf_en, 1'b1)
    `CHK(analog_o.temp_en, 1'b1)
    `CHK(analog_o.bg_line_en, 1'b0)
    `CHK(analog_s.ext_buf_en, 1'b0)
    `CHK(analog_s.bg_line_en, 1'b1)
    bus(1'b1, RCL_OFS_CTRL, 8'h85);
    settle();
    `CHK(analog_o.temp_en, 1'b0)
    // Force-on dropped while a generator and a line request are pending
    want <= 12'h440;
    bus(1'b1, RCL_OFS_CTRL, 8'h82);
    settle();
    `CHK(analog_o.gen_en, 1'b1)
    `CHK(analog_s.bg_line_en, 1'b1)
    `CHK(analog_s.afe_bias_en, 1'b0)
    want <= '0;
    settle();
    `CHK(analog_o.gen_en, 1'b0)
    `CHK(analog_s.bg_line_en, 1'b0)
    bus(1'b1, RCL_OFS_CTRL, 8'h01);
    settle();
    `CHK(analog_o.gen_en, 1'b0)
    bus(1'b1, RCL_OFS_LEGACY, 8'h03);
    settle();
    `CHK(analog_o.level, RCL_LVL_2V5)
    `CHK(analog_s.gen_en, 1'b0)
    bus(1'b0, RCL_OFS_STATUS, 8'h00);
    `CHK(d[RCL_STS_MASTER_BIT], 1'b0)
    // master set again before the random votes
    bus(1'b1, RCL_OFS_CTRL, 8'h80);
    // Random votes, first two fixed corners
    for (int i = 0; i < 80; i++)
    begin
      seed = xs(seed);
      w = (i == 0) ? 12'hf0f : (i == 1) ? 12'h00f : seed[11:0];
      want <= w;
      slow <= seed[12];
      repeat (4) @(posedge clk_i);
      #1;
      `CHK(analog_o.gen_en, |w.gen)
      `CHK(analog_o.sampled, exp_smp(w))
      `CHK(analog_s.sampled, exp_smp(w))
      bus(1'b0, RCL_OFS_STATUS, 8'h00);
      `CHK(d[RCL_STS_SAMPLED_BIT], exp_smp(w))
    end
    finish_test();
  end
endmodule
